// >>> shared/usr_pkg.sv
// Constants and types for the USB status report and command filter
// Function
// - Max power reads 0xfa when sense high, 0x01 when low; else stored byte 0x34.
// - Self-powered bit low when sense high, high when low; else from max power.
// - Sense level sampled into descriptor only at USB reset or power-on reset.
// - Outside party holds reset 10 ms; device then reinitialises all state (not the block memory here); usb_reset_i here only resamples the power fields.
// - All outputs hold default startup values while reset is asserted.
// - With HID present, input GPIOs are polled about every 17 ms.
// - A changed polled GPIO state queues a report on interrupt endpoint one.
// - Report is two bytes: GPIO 5..0 in byte 0, speed and bus-power in byte 1.
// - Direction per GPIO from config byte 0x09; non-inputs report as zero.
// - Device runs full or high speed only, never low speed.
// - Only blocks with matching signature and subcode are pass-through blocks.
// - Signature byte must equal the stored value from address 0x04.
// - Recognised pass-through blocks are forwarded to the drive.
// - Packet commands are routed for translation when drive is non-packet.
// - Empty endpoint answers NAK; pending data returns 16 bits.
package usr_pkg;
  localparam int CLK_MHZ = 250;
  localparam int POLL_MS = 17;
  localparam int POLL_CYCLES = POLL_MS * CLK_MHZ * 1000;
  localparam int RESET_HOLD_MS = 10;
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_MS * CLK_MHZ * 1000;
  localparam logic [7:0] MAXPWR_BUS = 8'hfa;
  localparam logic [7:0] MAXPWR_SELF = 8'h01;
  localparam logic [7:0] SUBCODE = 8'h24;
  localparam logic [4:0] CB_BYTES = 5'h10;
  localparam logic [7:0] CFG_ADDR_MAXPWR = 8'h34;
  localparam logic [7:0] CFG_ADDR_GPIO_DIR = 8'h09;
  localparam logic [7:0] CFG_ADDR_SIG = 8'h04;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_GPIO_DIR = 8'h04;
  localparam logic [7:0] OFF_MAXPWR = 8'h08;
  localparam logic [7:0] OFF_SIG = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_REPORT = 8'h14;
  localparam logic [7:0] OFF_CB_LEN = 8'h18;
  localparam logic [7:0] OFF_DESC = 8'h1c;
  localparam logic [1:0] CB_WIN_TOP = 2'h1;
  // Control fields
  localparam int CTRL_HID = 0;
  localparam int CTRL_SUBMIT = 1;
  localparam int CTRL_PACKET = 2;
  // Status fields
  localparam int ST_PEND = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_ROUTE = 2;
  // Report fields
  localparam int RPT_BUSPWR = 8;
  localparam int RPT_HS = 9;
  // Reset values
  localparam logic [5:0] GPIO_DIR_RST = 6'h00;
  localparam logic [7:0] MAXPWR_RST = 8'h01;
  localparam logic [7:0] SIG_RST = 8'h00;
  typedef enum logic [1:0] {
    USR_ROUTE_NONE,
    USR_ROUTE_PASSTHRU,
    USR_ROUTE_PACKET,
    USR_ROUTE_TRANSLATE
  } usr_route_e;
endpackage

// >>> shared/usr_cb_if.sv
// Command block memory port bundle
interface usr_cb_if;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [3:0] rd_addr;
  logic [7:0] rd_data;
  modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// >>> hdl/usr_cmd_mem.sv
// Sixteen-byte command block store with registered read
module usr_cmd_mem #(
  parameter int DEPTH = 16
) (
  // Clock
  input wire logic clock_i,
  // Port bundle
  usr_cb_if.mem cb
);
  logic [7:0] mem_reg [DEPTH];
  always_ff @(posedge clock_i) begin
    if (cb.wr_en) begin
      mem_reg[cb.wr_addr] <= cb.wr_data;
    end
  end
  always_ff @(posedge clock_i) begin
    cb.rd_data <= mem_reg[cb.rd_addr];
  end
endmodule // usr_cmd_mem

// >>> hdl/usr_poll_timer.sv
// Free-running poll interval tick
module usr_poll_timer #(
  parameter int CYCLES = 4250000
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Control
  input wire logic enable_i,
  output logic tick_o
);
  logic [31:0] cnt_reg;
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !enable_i) begin
      cnt_reg <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_reg == 32'(CYCLES - 1)) begin
      cnt_reg <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule // usr_poll_timer

// >>> hdl/usr_top.sv
// Status report and command filter top level
module usr_top #(
  parameter int POLL_CYCLES = usr_pkg::POLL_CYCLES,
  parameter bit HAS_SENSE_PIN = 1'b1,
  parameter int GPIO_W = 6
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // USB side status
  input wire logic usb_reset_i,
  input wire logic high_speed_i,
  input wire logic power_source_sense_i,
  // Descriptor power fields
  output logic [7:0] max_power_o,
  output logic self_powered_o,
  // Buttons
  input wire logic [GPIO_W-1:0] gpio_i,
  // Interrupt endpoint one
  input wire logic ep1_in_req_i,
  output logic ep1_nak_o,
  output logic ep1_valid_o,
  output logic [15:0] ep1_data_o,
  // Drive forwarding
  output logic fwd_valid_o,
  output logic [7:0] fwd_data_o,
  output logic fwd_last_o,
  output logic [1:0] fwd_route_o
);
  // Control state
  logic hid_en_reg;
  logic packet_drive_reg;
  logic [GPIO_W-1:0] gpio_dir_reg;
  logic [7:0] stored_maxpwr_reg;
  logic [7:0] sig_reg;
  logic [4:0] cb_len_reg;
  logic [7:0] cb_byte0_reg;
  logic [7:0] cb_byte1_reg;
  logic submit;
  logic cb_write;
  // Descriptor capture
  logic sample_pend_reg;
  // Report state
  logic poll_tick;
  logic [GPIO_W-1:0] gpio_last_reg;
  logic [GPIO_W-1:0] gpio_masked;
  logic [15:0] report_reg;
  logic pend_reg;
  logic report_new;
  logic report_served;
  // Forward engine
  typedef enum logic [1:0] {
    USR_FWD_IDLE,
    USR_FWD_READ,
    USR_FWD_DRAIN
  } usr_fwd_state_e;
  usr_fwd_state_e state_reg;
  logic [4:0] rd_cnt_reg;
  logic rd_valid_reg;
  logic rd_last_reg;
  logic [1:0] route_next;
  logic [1:0] route_reg;
  usr_cb_if cb ();

  assign submit = reg_we_i && (reg_addr_i == usr_pkg::OFF_CTRL) && reg_wdata_i[usr_pkg::CTRL_SUBMIT];
  assign cb_write = reg_we_i && (reg_addr_i[7:6] == usr_pkg::CB_WIN_TOP) && (state_reg == USR_FWD_IDLE);

  // Configuration writes
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      hid_en_reg <= 1'b0;
      packet_drive_reg <= 1'b0;
      gpio_dir_reg <= usr_pkg::GPIO_DIR_RST;
      stored_maxpwr_reg <= usr_pkg::MAXPWR_RST;
      sig_reg <= usr_pkg::SIG_RST;
      cb_len_reg <= usr_pkg::CB_BYTES;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        usr_pkg::OFF_CTRL: begin
          hid_en_reg <= reg_wdata_i[usr_pkg::CTRL_HID];
          packet_drive_reg <= reg_wdata_i[usr_pkg::CTRL_PACKET];
        end
        usr_pkg::OFF_GPIO_DIR: begin
          gpio_dir_reg <= reg_wdata_i[GPIO_W-1:0];
        end
        usr_pkg::OFF_MAXPWR: begin
          stored_maxpwr_reg <= reg_wdata_i[7:0];
        end
        usr_pkg::OFF_SIG: begin
          sig_reg <= reg_wdata_i[7:0];
        end
        usr_pkg::OFF_CB_LEN: begin
          cb_len_reg <= reg_wdata_i[4:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Shadow of the two leading bytes so the decision needs no memory read
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cb_byte0_reg <= 8'h00;
      cb_byte1_reg <= 8'h00;
    end else if (cb_write && reg_addr_i[5:2] == 4'h0) begin
      cb_byte0_reg <= reg_wdata_i[7:0];
    end else if (cb_write && reg_addr_i[5:2] == 4'h1) begin
      cb_byte1_reg <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      sample_pend_reg <= 1'b1;
    end else begin
      sample_pend_reg <= usb_reset_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      max_power_o <= usr_pkg::MAXPWR_SELF;
      self_powered_o <= 1'b1;
    end else if (sample_pend_reg) begin
      if (HAS_SENSE_PIN) begin
        max_power_o <= power_source_sense_i ? usr_pkg::MAXPWR_BUS : usr_pkg::MAXPWR_SELF;
        self_powered_o <= !power_source_sense_i;
      end else begin
        max_power_o <= stored_maxpwr_reg;
        self_powered_o <= (stored_maxpwr_reg <= usr_pkg::MAXPWR_SELF);
      end
    end
  end

  usr_poll_timer #(
    .CYCLES(POLL_CYCLES)
  ) u_timer (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .enable_i(hid_en_reg),
    .tick_o(poll_tick)
  );

  assign gpio_masked = gpio_i & gpio_dir_reg;
  assign report_new = poll_tick && hid_en_reg && (gpio_masked != gpio_last_reg);
  assign report_served = ep1_in_req_i && pend_reg;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      gpio_last_reg <= '0;
    end else if (poll_tick && hid_en_reg) begin
      gpio_last_reg <= gpio_masked;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      report_reg <= 16'h0000;
    end else if (report_new) begin
      report_reg <= 16'h0000;
      report_reg[GPIO_W-1:0] <= gpio_masked;
      report_reg[usr_pkg::RPT_BUSPWR] <= !self_powered_o;
      report_reg[usr_pkg::RPT_HS] <= high_speed_i;
    end
  end

  // New report beats a same-cycle read-out
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pend_reg <= 1'b0;
    end else if (report_new) begin
      pend_reg <= 1'b1;
    end else if (report_served) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ep1_nak_o <= 1'b0;
      ep1_valid_o <= 1'b0;
      ep1_data_o <= 16'h0000;
    end else begin
      ep1_nak_o <= ep1_in_req_i && !pend_reg;
      ep1_valid_o <= report_served;
      if (report_served) begin
        ep1_data_o <= report_reg;
      end
    end
  end

  always_comb begin
    if (cb_byte0_reg == sig_reg && cb_byte1_reg == usr_pkg::SUBCODE && cb_len_reg == usr_pkg::CB_BYTES) begin
      route_next = usr_pkg::USR_ROUTE_PASSTHRU;
    end else if (packet_drive_reg) begin
      route_next = usr_pkg::USR_ROUTE_PACKET;
    end else begin
      route_next = usr_pkg::USR_ROUTE_TRANSLATE;
    end
  end

  // Forward engine; writes to the block are refused while it streams
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_reg <= USR_FWD_IDLE;
      rd_cnt_reg <= 5'h00;
      route_reg <= usr_pkg::USR_ROUTE_NONE;
    end else begin
      case (state_reg)
        USR_FWD_IDLE: begin
          rd_cnt_reg <= 5'h00;
          if (submit && cb_len_reg != 5'h00) begin
            route_reg <= route_next;
            state_reg <= USR_FWD_READ;
          end
        end
        USR_FWD_READ: begin
          rd_cnt_reg <= rd_cnt_reg + 5'h01;
          if (rd_cnt_reg + 5'h01 >= cb_len_reg) begin
            state_reg <= USR_FWD_DRAIN;
          end
        end
        USR_FWD_DRAIN: begin
          if (!rd_valid_reg && !fwd_valid_o) begin
            state_reg <= USR_FWD_IDLE;
          end
        end
        default: begin
          state_reg <= USR_FWD_IDLE;
        end
      endcase
    end
  end

  assign cb.wr_en = cb_write;
  assign cb.wr_addr = reg_addr_i[5:2];
  assign cb.wr_data = reg_wdata_i[7:0];
  assign cb.rd_addr = rd_cnt_reg[3:0];

  usr_cmd_mem #(
    .DEPTH(16)
  ) u_mem (
    .clock_i(clock_i),
    .cb(cb)
  );

  // Memory read lags address by one cycle
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rd_valid_reg <= 1'b0;
      rd_last_reg <= 1'b0;
    end else begin
      rd_valid_reg <= (state_reg == USR_FWD_READ);
      rd_last_reg <= (state_reg == USR_FWD_READ) && (rd_cnt_reg + 5'h01 >= cb_len_reg);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      fwd_valid_o <= 1'b0;
      fwd_data_o <= 8'h00;
      fwd_last_o <= 1'b0;
      fwd_route_o <= usr_pkg::USR_ROUTE_NONE;
    end else begin
      fwd_valid_o <= rd_valid_reg;
      fwd_data_o <= rd_valid_reg ? cb.rd_data : 8'h00;
      fwd_last_o <= rd_last_reg;
      fwd_route_o <= rd_valid_reg ? route_reg : usr_pkg::USR_ROUTE_NONE;
    end
  end

  // Register reads, unmapped read as zero
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        usr_pkg::OFF_CTRL: begin
          reg_rdata_o <= {29'h0, packet_drive_reg, 1'b0, hid_en_reg};
        end
        usr_pkg::OFF_GPIO_DIR: begin
          reg_rdata_o <= 32'(gpio_dir_reg);
        end
        usr_pkg::OFF_MAXPWR: begin
          reg_rdata_o <= {24'h0, stored_maxpwr_reg};
        end
        usr_pkg::OFF_SIG: begin
          reg_rdata_o <= {24'h0, sig_reg};
        end
        usr_pkg::OFF_STATUS: begin
          reg_rdata_o <= {28'h0, route_reg, state_reg != USR_FWD_IDLE, pend_reg};
        end
        usr_pkg::OFF_REPORT: begin
          reg_rdata_o <= {16'h0, report_reg};
        end
        usr_pkg::OFF_CB_LEN: begin
          reg_rdata_o <= {27'h0, cb_len_reg};
        end
        usr_pkg::OFF_DESC: begin
          reg_rdata_o <= {23'h0, self_powered_o, max_power_o};
        end
        default: begin
          reg_rdata_o <= 32'h0;
        end
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end
endmodule // usr_top

// >>> dv/usr_host_model.sv
// Host-side model polling interrupt endpoint one
module usr_host_model #(
  parameter logic [15:0] USED_MASK = 16'h033f
) (
  // Clock
  input wire logic clock_i,
  // Poll command from bench
  input wire logic go_i,
  output logic ep1_in_req_o,
  // Endpoint answer
  input wire logic ep1_valid_i,
  input wire logic [15:0] ep1_data_i,
  output logic [15:0] report_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ep1_in_req_o = 1'b0;
  initial report_o = 16'h0000;
  // One request per cycle of go
  always @(posedge clock_i) ep1_in_req_o <= go_i;
  always @(posedge clock_i) if (ep1_valid_i) report_o <= ep1_data_i & USED_MASK;
endmodule // usr_host_model

// >>> dv/usr_top_sva.sv
// Checker for the status report and command filter ports
module usr_top_sva (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic usb_reset_i,
  input wire logic power_source_sense_i,
  input wire logic [7:0] max_power_o,
  input wire logic self_powered_o,
  input wire logic ep1_in_req_i,
  input wire logic ep1_nak_o,
  input wire logic ep1_valid_o,
  input wire logic [15:0] ep1_data_o,
  input wire logic fwd_valid_o,
  input wire logic [7:0] fwd_data_o,
  input wire logic fwd_last_o,
  input wire logic [1:0] fwd_route_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin is taken the edge after the reset, value shows one edge later
  property p_maxpwr;
    @(posedge clock_i) disable iff (!reset_n_i)
    usb_reset_i |-> ##2 max_power_o == ($past(power_source_sense_i) ? 8'hfa : 8'h01);
  endproperty
  a_maxpwr: assert property (p_maxpwr) else $error("max power wrong after usb reset");
  property p_selfpwr;
    @(posedge clock_i) disable iff (!reset_n_i) usb_reset_i |-> ##2 self_powered_o == !$past(power_source_sense_i);
  endproperty
  a_selfpwr: assert property (p_selfpwr) else $error("self powered bit wrong");
  // Held between resets, whatever the pin does
  property p_hold;
    @(posedge clock_i) disable iff (!reset_n_i)
    ($past(reset_n_i) && $past(reset_n_i, 2) && $past(reset_n_i, 3) && !$past(usb_reset_i, 2))
    |-> $stable(max_power_o) && $stable(self_powered_o);
  endproperty
  a_hold: assert property (p_hold) else $error("descriptor changed without reset");
  // No disable here: the reset itself is the cause
  property p_rst;
    @(posedge clock_i) !reset_n_i |=> max_power_o == 8'h01 && self_powered_o && !ep1_valid_o && !ep1_nak_o
      && !fwd_valid_o && fwd_route_o == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at startup state");
  property p_answer;
    @(posedge clock_i) disable iff (!reset_n_i) ep1_in_req_i |=> ep1_valid_o != ep1_nak_o;
  endproperty
  a_answer: assert property (p_answer) else $error("endpoint request not answered once");
  property p_cause;
    @(posedge clock_i) disable iff (!reset_n_i) (ep1_valid_o || ep1_nak_o) |-> $past(ep1_in_req_i);
  endproperty
  a_cause: assert property (p_cause) else $error("endpoint answer without request");
  property p_format;
    @(posedge clock_i) disable iff (!reset_n_i) ep1_valid_o |-> ep1_data_o[15:10] == 6'h0 && ep1_data_o[7:6] == 2'h0;
  endproperty
  a_format: assert property (p_format) else $error("reserved report bits set");
  property p_fwd;
    @(posedge clock_i) disable iff (!reset_n_i)
    (fwd_last_o |-> fwd_valid_o) and (!fwd_valid_o |-> fwd_data_o == 8'h00) and (fwd_valid_o |-> fwd_route_o != 2'h0);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward framing broken");
  property p_len16;
    @(posedge clock_i) disable iff (!reset_n_i)
    ($rose(fwd_valid_o) && fwd_route_o == 2'h1) |-> fwd_valid_o[*8] ##1 fwd_valid_o[*8] ##0 fwd_last_o;
  endproperty
  a_len16: assert property (p_len16) else $error("pass-through not sixteen bytes");
  c_pass: cover property (@(posedge clock_i) fwd_last_o && fwd_route_o == 2'h1);
  c_rpt: cover property (@(posedge clock_i) ep1_valid_o ##1 ep1_nak_o);
  c_bus: cover property (@(posedge clock_i) max_power_o == 8'hfa);
endmodule // usr_top_sva
bind usr_top usr_top_sva i_sva (.clock_i(clock_i), .reset_n_i(reset_n_i), .usb_reset_i(usb_reset_i),
  .power_source_sense_i(power_source_sense_i), .max_power_o(max_power_o), .self_powered_o(self_powered_o),
  .ep1_in_req_i(ep1_in_req_i), .ep1_nak_o(ep1_nak_o), .ep1_valid_o(ep1_valid_o), .ep1_data_o(ep1_data_o),
  .fwd_valid_o(fwd_valid_o), .fwd_data_o(fwd_data_o), .fwd_last_o(fwd_last_o), .fwd_route_o(fwd_route_o));

// >>> dv/usr_top_tb.sv
// Self-checking bench for the status report and command filter
module usr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic usb_reset_i = 1'b0;
  logic high_speed_i = 1'b0;
  logic power_source_sense_i = 1'b0;
  logic [5:0] gpio_i = 6'h00;
  logic go = 1'b0;
  logic re_d = 1'b0;
  logic ep1_in_req_i, ep1_nak_o, ep1_valid_o, fwd_valid_o, fwd_last_o, self_powered_o;
  logic [31:0] reg_rdata_o;
  logic [7:0] max_power_o, fwd_data_o, sig, b;
  logic [15:0] ep1_data_o, host_rpt;
  logic [1:0] fwd_route_o;
  logic [5:0] dir, g;
  logic [16:0] ep_e;
  logic [31:0] rd_q[$];
  logic [16:0] ep_q[$];
  logic [10:0] fw_q[$];
  int bad_count = 0;
  int num_checks = 0;
  int seed = 44;
  always #2 clock_i = ~clock_i;
  usr_top #(.POLL_CYCLES(20)) i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .usb_reset_i(usb_reset_i), .high_speed_i(high_speed_i), .power_source_sense_i(power_source_sense_i),
    .max_power_o(max_power_o), .self_powered_o(self_powered_o), .gpio_i(gpio_i), .ep1_in_req_i(ep1_in_req_i),
    .ep1_nak_o(ep1_nak_o), .ep1_valid_o(ep1_valid_o), .ep1_data_o(ep1_data_o), .fwd_valid_o(fwd_valid_o),
    .fwd_data_o(fwd_data_o), .fwd_last_o(fwd_last_o), .fwd_route_o(fwd_route_o));
  usr_host_model i_host (.clock_i(clock_i), .go_i(go), .ep1_in_req_o(ep1_in_req_i), .ep1_valid_i(ep1_valid_o),
    .ep1_data_i(ep1_data_o), .report_o(host_rpt));
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clock_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clock_i);
    reg_re_i <= 1'b0;
  endtask
  task automatic ask(input int n);
    @(posedge clock_i);
    go <= 1'b1;
    cyc(n);
    go <= 1'b0;
  endtask
  // Outputs sampled at the edge after they were launched
  always @(posedge clock_i) begin
    re_d <= reg_re_i;
    if (re_d) begin
      if (rd_q.size() == 0) chk(1'b0, "unexpected read");
      else chk(reg_rdata_o === rd_q.pop_front(), "read data");
    end
    if (ep1_valid_o === 1'b1 || ep1_nak_o === 1'b1) begin
      ep_e = (ep_q.size() == 0) ? 17'h0 : ep_q.pop_front();
      chk(ep1_nak_o === ep_e[16] && (ep_e[16] || ep1_data_o === ep_e[15:0]), "endpoint answer");
    end
    if (fwd_valid_o === 1'b1) begin
      if (fw_q.size() == 0) chk(1'b0, "unexpected forward byte");
      else chk({fwd_route_o, fwd_last_o, fwd_data_o} === fw_q.pop_front(), "forward byte");
    end
  end
  initial begin
    cyc(15);
    #1;
    chk(max_power_o === 8'h01 && self_powered_o === 1'b1 && fwd_valid_o === 1'b0, "startup state");
    @(posedge clock_i);
    reset_n_i <= 1'b1;
    rd(usr_pkg::OFF_GPIO_DIR, 32'h0);
    rd(usr_pkg::OFF_MAXPWR, 32'h1);
    rd(usr_pkg::OFF_SIG, 32'h0);
    rd(usr_pkg::OFF_CB_LEN, 32'h10);
    rd(8'h20, 32'h0);
    for (int s = 0; s < 2; s++) begin
      @(posedge clock_i);
      power_source_sense_i <= s[0];
      usb_reset_i <= 1'b1;
      @(posedge clock_i);
      usb_reset_i <= 1'b0;
      cyc(2);
      #1;
      chk(max_power_o === (s[0] ? 8'hfa : 8'h01) && self_powered_o === !s[0], "descriptor");
      rd(usr_pkg::OFF_DESC, {23'h0, !s[0], s[0] ? 8'hfa : 8'h01});
    end
    @(posedge clock_i);
    power_source_sense_i <= 1'b0;
    cyc(4);
    #1;
    chk(max_power_o === 8'hfa && self_powered_o === 1'b0, "descriptor held");
    // Bit 0 set in both, so the first poll always sees a change
    g = 6'($random(seed)) | 6'h01;
    dir = 6'($random(seed)) | 6'h01;
    @(posedge clock_i);
    high_speed_i <= 1'($random(seed));
    gpio_i <= g;
    cyc(60);
    ep_q.push_back(17'h10000);
    ask(1);
    wr(usr_pkg::OFF_GPIO_DIR, {26'h0, dir});
    wr(usr_pkg::OFF_CTRL, 32'h1);
    cyc(60);
    ep_q.push_back({1'b0, 6'h0, high_speed_i, 1'b1, 2'h0, g & dir});
    ep_q.push_back(17'h10000);
    ask(2);
    gpio_i <= g ^ ~dir;
    cyc(60);
    ep_q.push_back(17'h10000);
    ask(1);
    gpio_i <= ~g;
    cyc(60);
    ep_q.push_back({1'b0, 6'h0, high_speed_i, 1'b1, 2'h0, ~g & dir});
    ask(1);
    cyc(3);
    chk(host_rpt === {6'h0, high_speed_i, 1'b1, 2'h0, ~g & dir}, "host report");
    sig = 8'($random(seed));
    wr(usr_pkg::OFF_SIG, {24'h0, sig});
    // Only the subcode differs, so the signature compare alone cannot pass
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 16; i++) begin
        b = (i == 0) ? sig : (i == 1) ? ((k == 0) ? 8'h24 : 8'h25) : 8'($random(seed));
        wr(8'h40 + 8'(i * 4), {24'h0, b});
        fw_q.push_back({2'(k + 1), i == 15, b});
      end
      // Drive kind set first: the route takes the value held before the submit edge
      wr(usr_pkg::OFF_CTRL, {29'h0, k == 1, 2'h1});
      wr(usr_pkg::OFF_CTRL, {29'h0, k == 1, 2'h3});
      wr(usr_pkg::OFF_CTRL, {29'h0, k == 1, 2'h3});
      for (int t = 0; t < 40 && fwd_last_o !== 1'b1; t++) @(posedge clock_i);
      cyc(4);
    end
    rd(usr_pkg::OFF_STATUS, 32'hc);
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    cyc(3);
    reset_n_i <= 1'b1;
    rd(usr_pkg::OFF_GPIO_DIR, 32'h0);
    rd(usr_pkg::OFF_CTRL, 32'h0);
    cyc(4);
    chk(rd_q.size() == 0 && ep_q.size() == 0 && fw_q.size() == 0, "results missing");
    tally_and_finish();
  end
  // Whole run is a few hundred cycles
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule // usr_top_tb
